// File: dv/main_clock_monitor_reset_monitor.sv
`timescale 1ns/100ps
module main_clock_monitor_reset_monitor (
   input wire logic clk,
   input wire logic srst,
   input wire logic main_clk_pin,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic monitor_reset_req,
   input wire logic cpu_run,
   input wire logic firmware_run,
   input wire logic watchdog_run,
   input wire logic internal_osc_on
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // ========================================
   // cycles since the main clock pin last moved
   logic       last_pin;
   logic [9:0] quiet;
   always_ff @(posedge clk) begin
      last_pin <= main_clk_pin;
      if (srst || main_clk_pin != last_pin) quiet <= 10'h000;
      else if (quiet != 10'h3ff) quiet <= quiet + 10'h001;
   end
   // ========================================
   // properties
   sequence write_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   write_answer_a: assert property (write_taken |-> ##[1:2] bvalid)
      else $error("write response missing");
   read_answer_a: assert property (arvalid && arready |=> rvalid)
      else $error("read response missing");
   read_refuse_a: assert property (rvalid |-> !arready)
      else $error("read taken while answer pending");
   write_refuse_a: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while answer pending");
   watchdog_restart_a: assert property ($fell(watchdog_run) |-> ##[1:8] watchdog_run)
      else $error("watchdog not restarted");
   run_exclusive_a: assert property (!(cpu_run && firmware_run))
      else $error("firmware and program both running");
   firmware_first_a: assert property ($rose(cpu_run) |-> $past(firmware_run))
      else $error("program started without firmware phase");
   miss_window_a: assert property ($rose(monitor_reset_req) |-> quiet >= 10'd5)
      else $error("stop declared with main clock moving");
   osc_stop_quiet_a: assert property (!internal_osc_on |-> !monitor_reset_req)
      else $error("monitor active with sampling osc stopped");
   monitor_resets_run_a: assert property (monitor_reset_req |=> ##[0:3] !cpu_run && !firmware_run)
      else $error("monitor reset left cpu running");
endmodule : main_clock_monitor_reset_monitor

bind main_clock_monitor_reset main_clock_monitor_reset_monitor u_monitor (.clk, .srst, .main_clk_pin, .awvalid,
   .awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .monitor_reset_req, .cpu_run, .firmware_run,
   .watchdog_run, .internal_osc_on);

// File: dv/main_clock_monitor_reset_tb.sv
`timescale 1ns/100ps
module main_clock_monitor_reset_tb;
   import clock_watch_pkg::*;
   // ========================================
   // signals
   logic        clk = 1'b0, srst = 1'b1, pin_reset = 1'b0, watchdog_reset_req = 1'b0;
   logic        undervoltage_reset_req = 1'b0, main_clk_pin = 1'b0, internal_osc_tick = 1'b0;
   logic        firmware_done = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
   logic        rready = 1'b0, awready, wready, bvalid, arready, rvalid, run_main = 1'b0, seen_req = 1'b0;
   logic        monitor_reset_req, cpu_run, firmware_run, watchdog_run, internal_osc_on, irq;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, cause = 32'h0;
   logic [3:0]  wstrb = 4'h1;
   logic [1:0]  bresp, rresp;
   int          errors = 0, comparisons = 0, cycles = 0, tick_div = 32, tick_cnt = 0;
   main_clock_monitor_reset dut (.clk, .srst, .pin_reset, .watchdog_reset_req, .undervoltage_reset_req,
      .main_clk_pin, .internal_osc_tick, .firmware_done, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .monitor_reset_req, .cpu_run, .firmware_run, .watchdog_run, .internal_osc_on, .irq);
   always #4 clk = ~clk;
   // main clock toggles every cycle while run_main is set; ticks stop while the device stops its osc
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (run_main) main_clk_pin <= ~main_clk_pin;
      tick_cnt <= (tick_cnt + 1 >= tick_div) ? 0 : tick_cnt + 1;
      internal_osc_tick <= (tick_cnt == 0) && (internal_osc_on === 1'b1);
      if (monitor_reset_req === 1'b1) seen_req <= 1'b1;
      if (cycles == 95000) begin
         errors++;
         end_of_test();
      end
   end
   // ========================================
   // tasks
   task automatic end_of_test();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [31:0] cause_next(input logic [31:0] c, input int src);
      case (src)
         0: return 32'h0;
         1: return c | (32'h1 << bit_watchdog_flag);
         2: return c | (32'h1 << bit_monitor_flag);
         default: return c | (32'h1 << bit_undervoltage_flag);
      endcase
   endfunction : cause_next
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 50);
      bready <= 1'b0;
      check(bvalid, 1);
      check(bresp, 2'b00);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 50);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      check(rvalid, 1);
   endtask : rd
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      check(d, e);
   endtask : rdchk
   task automatic guarded(input logic [31:0] v);
      wr(off_protect_key, {24'h0, protect_key_value});
      wr(off_watch_control, v);
   endtask : guarded
   task automatic pulse(input int which, input int len);
      @(posedge clk);
      case (which)
         0: pin_reset <= 1'b1;
         1: watchdog_reset_req <= 1'b1;
         2: undervoltage_reset_req <= 1'b1;
         default: firmware_done <= 1'b1;
      endcase
      repeat (len) @(posedge clk);
      {pin_reset, watchdog_reset_req, undervoltage_reset_req, firmware_done} <= 4'h0;
   endtask : pulse
   task automatic wait_hi(ref logic s, input int lim);
      int n;
      n = 0;
      while (s !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_hi
   // ========================================
   // main sequence
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      int          t0;
      void'($urandom(32'h1145));
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      pulse(0, 2);
      repeat (6) @(posedge clk);
      check(watchdog_run, 1);
      check(cpu_run | firmware_run, 0);
      run_main <= 1'b1;
      t0 = cycles;
      rdchk(off_watch_control, 0);
      rdchk(off_reset_cause, 0);
      wr(off_watch_control, $urandom | 32'h1);
      rdchk(off_watch_control, 0);
      wr(off_protect_key, {24'h0, protect_key_value});
      wr(off_irq_mask, 32'h0);
      wr(off_watch_control, 32'h1);
      rdchk(off_watch_control, 0);
      rd(8'h20 + 8'(($urandom % 56) * 4), d, r);
      check(r, 2'b10);
      check(d, 0);
      wait_hi(firmware_run, 70000);
      check(cycles - t0 >= 65536 && cycles - t0 < 65600, 1);
      check(cpu_run, 0);
      pulse(3, 1);
      wait_hi(cpu_run, 10);
      check(firmware_run, 0);
      rdchk(off_cpu_clock_status, 0);
      rdchk(off_irq_status, 32'h1 << irq_cpu_started);
      wr(off_irq_status, 32'h1 << irq_cpu_started);
      guarded(1);
      rdchk(off_watch_control, 1);
      guarded(0);
      rdchk(off_watch_control, 1);
      // main osc stopped on purpose during subclock operation
      wr(off_power_clock, 32'h50);
      seen_req <= 1'b0;
      run_main <= 1'b0;
      repeat (300 + $urandom % 200) @(posedge clk);
      run_main <= 1'b1;
      repeat (20) @(posedge clk);
      wr(off_power_clock, 32'h0);
      repeat (300) @(posedge clk);
      check(seen_req, 0);
      wr(off_internal_osc, 32'h1);
      repeat (4) @(posedge clk);
      check(internal_osc_on, 0);
      run_main <= 1'b0;
      repeat (400) @(posedge clk);
      run_main <= 1'b1;
      wr(off_internal_osc, 32'h0);
      repeat (300) @(posedge clk);
      check(seen_req, 0);
      check(internal_osc_on, 1);
      t0 = cycles;
      run_main <= 1'b0;
      wait_hi(monitor_reset_req, 600);
      check(cycles - t0 >= 224 && cycles - t0 <= 320, 1);
      t0 = cycles;
      tick_div <= 2;
      cause = cause_next(cause, 2);
      repeat (4) @(posedge clk);
      check(cpu_run, 0);
      rdchk(off_reset_cause, cause);
      rdchk(off_watch_control, 0);
      check(irq, 1);
      wr(off_irq_mask, 32'h1);
      repeat (2) @(posedge clk);
      check(irq, 0);
      wr(off_irq_status, 32'h1);
      wr(off_irq_mask, 32'h0);
      rdchk(off_irq_status, 0);
      repeat (2) @(posedge clk);
      check(irq, 0);
      // emergent start: no main clock, watchdog overflows in settle
      wait_hi(firmware_run, 9000);
      check(cycles - t0 >= 8000 && cycles - t0 <= 8400, 1);
      rdchk(off_irq_status, 32'h1 << irq_watchdog_reset);
      pulse(3, 1);
      wait_hi(cpu_run, 10);
      rdchk(off_cpu_clock_status, 1);
      wr(off_internal_osc, 32'h1);
      repeat (4) @(posedge clk);
      check(internal_osc_on, 1);
      guarded(1);
      seen_req <= 1'b0;
      repeat (200) @(posedge clk);
      check(seen_req, 0);
      check(cpu_run, 1);
      pulse(1, 1);
      cause = cause_next(cause, 1);
      rdchk(off_reset_cause, cause);
      pulse(2, 1);
      cause = cause_next(cause, 3);
      rdchk(off_reset_cause, cause);
      pulse(0, 2);
      repeat (6) @(posedge clk);
      rdchk(off_reset_cause, cause_next(cause, 0));
      rdchk(off_watch_control, 0);
      end_of_test();
   end
endmodule : main_clock_monitor_reset_tb

// File: shared/clock_watch_pkg.sv
package clock_watch_pkg;
   // ========================================
   // register byte offsets
   localparam logic [7:0] off_watch_control = 8'h00;
   localparam logic [7:0] off_cpu_clock_status = 8'h04;
   localparam logic [7:0] off_reset_cause = 8'h08;
   localparam logic [7:0] off_power_clock = 8'h0c;
   localparam logic [7:0] off_internal_osc = 8'h10;
   localparam logic [7:0] off_irq_status = 8'h14;
   localparam logic [7:0] off_irq_mask = 8'h18;
   localparam logic [7:0] off_protect_key = 8'h1c;
   // ========================================
   // field positions
   localparam int bit_monitor_enable = 0;
   localparam int bit_cpu_on_internal_osc = 0;
   localparam int bit_watchdog_flag = 4;
   localparam int bit_monitor_flag = 1;
   localparam int bit_undervoltage_flag = 0;
   localparam int bit_main_osc_stop = 6;
   localparam int bit_subclock_select = 4;
   localparam int bit_stop_mode = 0;
   localparam int bit_internal_osc_stop = 0;
   localparam int irq_count = 3;
   localparam int irq_monitor_reset = 0;
   localparam int irq_watchdog_reset = 1;
   localparam int irq_cpu_started = 2;
   // ========================================
   // reset values and keys
   localparam logic [7:0] watch_control_reset = 8'h00;
   localparam logic [7:0] protect_key_value = 8'ha5;
   // ========================================
   // timing
   localparam int settle_exponent = 16;
   localparam logic [16:0] settle_count = 17'h10000;
   localparam logic [7:0] miss_limit = 8'h08;
   localparam logic [11:0] watchdog_limit = 12'hfff;
   typedef enum logic [1:0] {st_settle, st_run_main, st_run_internal} boot_state_t;
endpackage : clock_watch_pkg

// File: shared/main_clock_detect_if.sv
`timescale 1ns/100ps
interface main_clock_detect_if;
   logic active;
   logic stopped;
   modport watcher (input active, output stopped);
   modport owner   (output active, input stopped);
endinterface : main_clock_detect_if

// File: verilog/clock_watch_axi_slave.sv
`timescale 1ns/100ps
module clock_watch_axi_slave
   import clock_watch_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic [7:0]  awaddr,
   input wire logic        awvalid,
   output logic            awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0]  wstrb,
   input wire logic        wvalid,
   output logic            wready,
   output logic [1:0]      bresp,
   output logic            bvalid,
   input wire logic        bready,
   input wire logic [7:0]  araddr,
   input wire logic        arvalid,
   output logic            arready,
   output logic [31:0]     rdata,
   output logic [1:0]      rresp,
   output logic            rvalid,
   input wire logic        rready,
   output logic            wr_strobe,
   output logic [7:0]      wr_addr,
   output logic [31:0]     wr_data,
   output logic [3:0]      wr_strb,
   output logic [7:0]      rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic        rd_hit,
   input wire logic        wr_hit
);
   logic have_aw;
   logic have_w;
   wire  do_write = have_aw && have_w && !bvalid;
   wire  do_read  = arvalid && !rvalid;
   assign awready = !have_aw && !bvalid;
   assign wready  = !have_w && !bvalid;
   assign arready = do_read;
   assign rd_addr = araddr;
   assign wr_strobe = do_write;
   // ========================================
   // write channel capture
   always_ff @(posedge clk) begin
      if (srst) begin
         have_aw <= 1'b0;
         have_w  <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= 2'b00;
      end else begin
         if (awvalid && awready) begin
            have_aw <= 1'b1;
            wr_addr <= awaddr;
         end
         if (wvalid && wready) begin
            have_w  <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (do_write) begin
            have_aw <= 1'b0;
            have_w  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= wr_hit ? 2'b00 : 2'b10;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end
   // ========================================
   // read channel
   always_ff @(posedge clk) begin
      if (srst) begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= 2'b00;
      end else if (do_read) begin
         rvalid <= 1'b1;
         rdata  <= rd_hit ? rd_data : 32'h00000000;
         rresp  <= rd_hit ? 2'b00 : 2'b10;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule : clock_watch_axi_slave

// File: verilog/main_clock_detector.sv
`timescale 1ns/100ps
module main_clock_detector
   import clock_watch_pkg::*;
(
   input wire logic             clk,
   input wire logic             srst,
   input wire logic             internal_osc_tick,
   input wire logic             main_clk_edge,
   main_clock_detect_if.watcher det
);
   logic [7:0] misses;
   wire        expired = (misses >= miss_limit);
   // ========================================
   // count internal-osc samples with no main-clock edge
   always_ff @(posedge clk) begin
      if (srst || !det.active || main_clk_edge) begin
         misses <= 8'h00;
      end else if (internal_osc_tick && !expired) begin
         misses <= misses + 8'h01;
      end
   end
   assign det.stopped = det.active && expired;
endmodule : main_clock_detector

// File: verilog/main_clock_monitor_reset.sv
`timescale 1ns/100ps
module main_clock_monitor_reset
   import clock_watch_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        pin_reset,
   input wire logic        watchdog_reset_req,
   input wire logic        undervoltage_reset_req,
   input wire logic        main_clk_pin,
   input wire logic        internal_osc_tick,
   input wire logic        firmware_done,
   input wire logic [7:0]  awaddr,
   input wire logic        awvalid,
   output logic            awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0]  wstrb,
   input wire logic        wvalid,
   output logic            wready,
   output logic [1:0]      bresp,
   output logic            bvalid,
   input wire logic        bready,
   input wire logic [7:0]  araddr,
   input wire logic        arvalid,
   output logic            arready,
   output logic [31:0]     rdata,
   output logic [1:0]      rresp,
   output logic            rvalid,
   input wire logic        rready,
   output logic            monitor_reset_req,
   output logic            cpu_run,
   output logic            firmware_run,
   output logic            watchdog_run,
   output logic            internal_osc_on,
   output logic            irq
);
   // ========================================
   // pin synchronisers
   logic [2:0] main_sync;
   logic [1:0] pin_rst_sync;
   always_ff @(posedge clk) begin
      if (srst) begin
         main_sync    <= 3'b000;
         pin_rst_sync <= 2'b00;
      end else begin
         main_sync    <= {main_sync[1:0], main_clk_pin};
         pin_rst_sync <= {pin_rst_sync[0], pin_reset};
      end
   end
   wire main_clk_edge = main_sync[2] != main_sync[1];
   wire pin_rst = pin_rst_sync[1];

   // ========================================
   // registers
   logic              monitor_enable_bit;
   logic              watchdog_reset_flag;
   logic              monitor_reset_flag;
   logic              undervoltage_reset_flag;
   logic              main_osc_stop_bit;
   logic              subclock_select_status;
   logic              stop_mode;
   logic              internal_osc_stop_bit;
   logic              unlocked;
   logic [irq_count-1:0] irq_status;
   logic [irq_count-1:0] irq_mask;
   boot_state_t       boot_state;
   logic [16:0]       settle_cnt;
   logic [11:0]       watchdog_cnt;
   logic              stop_settling;

   wire cpu_on_internal_osc_flag = (boot_state == st_run_internal);

   // ========================================
   // bus slave
   logic        wr_strobe;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   wire wr_hit = wr_addr[1:0] == 2'b00 && wr_addr <= off_protect_key;
   wire rd_hit = rd_addr[1:0] == 2'b00 && rd_addr <= off_protect_key;

   clock_watch_axi_slave u_bus (
      .clk     (clk),
      .srst    (srst),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr_strobe (wr_strobe),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_hit  (rd_hit),
      .wr_hit  (wr_hit)
   );

   wire wr_lane0     = wr_strobe && wr_strb[0];
   wire wr_key       = wr_lane0 && wr_addr == off_protect_key;
   wire wr_control   = wr_lane0 && wr_addr == off_watch_control;
   wire wr_power     = wr_lane0 && wr_addr == off_power_clock;
   wire wr_int_osc   = wr_lane0 && wr_addr == off_internal_osc;
   wire wr_irq_stat  = wr_lane0 && wr_addr == off_irq_status;
   wire wr_irq_mask  = wr_lane0 && wr_addr == off_irq_mask;
   // protected write: key then control in the very next write
   wire control_take = wr_control && unlocked;

   // ========================================
   // read mux
   wire [7:0] control_rd = {7'h00, monitor_enable_bit};
   wire [7:0] status_rd  = {7'h00, cpu_on_internal_osc_flag};
   wire [7:0] cause_rd   = {3'h0, watchdog_reset_flag, 2'h0, monitor_reset_flag, undervoltage_reset_flag};
   wire [7:0] power_rd   = {1'b0, main_osc_stop_bit, 1'b0, subclock_select_status, 3'h0, stop_mode};
   wire [7:0] int_osc_rd = {7'h00, internal_osc_stop_bit};
   wire [7:0] istat_rd   = {5'h00, irq_status};
   wire [7:0] imask_rd   = {5'h00, irq_mask};
   wire [7:0] rd_byte = (rd_addr == off_watch_control)    ? control_rd :
                        (rd_addr == off_cpu_clock_status) ? status_rd  :
                        (rd_addr == off_reset_cause)      ? cause_rd   :
                        (rd_addr == off_power_clock)      ? power_rd   :
                        (rd_addr == off_internal_osc)     ? int_osc_rd :
                        (rd_addr == off_irq_status)       ? istat_rd   :
                        (rd_addr == off_irq_mask)         ? imask_rd   : 8'h00;
   assign rd_data = {24'h000000, rd_byte};

   // ========================================
   // clock-stop detector
   main_clock_detect_if det_bus ();
   wire internal_osc_running = !internal_osc_stop_bit;
   assign det_bus.active = monitor_enable_bit
                        && boot_state == st_run_main
                        && !stop_mode && !stop_settling
                        && !main_osc_stop_bit && !subclock_select_status
                        && internal_osc_running
                        && !cpu_on_internal_osc_flag;

   main_clock_detector u_detect (
      .clk               (clk),
      .srst              (srst),
      .internal_osc_tick (internal_osc_tick && internal_osc_running),
      .main_clk_edge     (main_clk_edge),
      .det               (det_bus)
   );
   wire clock_fail = det_bus.stopped;

   // ========================================
   // boot sequence
   wire settle_done = settle_cnt == settle_count;
   wire wdt_ovf     = watchdog_cnt == watchdog_limit;
   always_ff @(posedge clk) begin
      if (srst || pin_rst || clock_fail) begin
         boot_state   <= st_settle;
         settle_cnt   <= 17'h00000;
         watchdog_cnt <= 12'h000;
      end else begin
         if (internal_osc_tick && !wdt_ovf) begin
            watchdog_cnt <= watchdog_cnt + 12'h001;
         end
         if ((boot_state == st_settle || stop_settling) && main_clk_edge && !settle_done) begin
            settle_cnt <= settle_cnt + 17'h00001;
         end else if (stop_mode) begin
            settle_cnt <= 17'h00000;
         end
         case (boot_state)
            st_settle: begin
               if (settle_done) begin
                  boot_state <= st_run_main;
               end else if (wdt_ovf) begin
                  boot_state <= st_run_internal;
               end
            end
            st_run_main: boot_state <= st_run_main;
            st_run_internal: boot_state <= st_run_internal;
            default: boot_state <= st_settle;
         endcase
      end
   end

   // ========================================
   // control and power state
   always_ff @(posedge clk) begin
      if (srst || pin_rst || clock_fail) begin
         monitor_enable_bit <= watch_control_reset[bit_monitor_enable];
         unlocked           <= 1'b0;
         main_osc_stop_bit  <= 1'b0;
         subclock_select_status <= 1'b0;
         stop_mode          <= 1'b0;
         stop_settling      <= 1'b0;
         internal_osc_stop_bit <= 1'b0;
      end else begin
         if (wr_strobe) begin
            unlocked <= wr_key && wr_data[7:0] == protect_key_value;
         end
         if (control_take && wr_data[bit_monitor_enable]) begin
            monitor_enable_bit <= 1'b1;
         end
         if (wr_power) begin
            main_osc_stop_bit      <= wr_data[bit_main_osc_stop];
            subclock_select_status <= wr_data[bit_subclock_select];
            stop_mode              <= wr_data[bit_stop_mode];
            if (stop_mode && !wr_data[bit_stop_mode]) begin
               stop_settling <= 1'b1;
            end
         end
         if (stop_settling && settle_done) begin
            stop_settling <= 1'b0;
         end
         if (wr_int_osc && !cpu_on_internal_osc_flag) begin
            internal_osc_stop_bit <= wr_data[bit_internal_osc_stop];
         end
      end
   end

   // ========================================
   // reset-cause flags survive all but srst and the pin reset
   always_ff @(posedge clk) begin
      if (srst || pin_rst) begin
         watchdog_reset_flag     <= 1'b0;
         monitor_reset_flag      <= 1'b0;
         undervoltage_reset_flag <= 1'b0;
      end else begin
         if (watchdog_reset_req) begin
            watchdog_reset_flag <= 1'b1;
         end
         if (clock_fail) begin
            monitor_reset_flag <= 1'b1;
         end
         if (undervoltage_reset_req) begin
            undervoltage_reset_flag <= 1'b1;
         end
      end
   end

   // ========================================
   // interrupts: set wins over write-one-to-clear
   logic [irq_count-1:0] irq_event;
   assign irq_event[irq_monitor_reset]  = clock_fail;
   assign irq_event[irq_watchdog_reset] = wdt_ovf && boot_state == st_settle;
   assign irq_event[irq_cpu_started]    = firmware_run && firmware_done;
   genvar g;
   generate
      for (g = 0; g < irq_count; g++) begin : g_irq
         always_ff @(posedge clk) begin
            if (srst) begin
               irq_status[g] <= 1'b0;
            end else if (irq_event[g]) begin
               irq_status[g] <= 1'b1;
            end else if (wr_irq_stat && wr_data[g]) begin
               irq_status[g] <= 1'b0;
            end
         end
      end
   endgenerate
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_mask <= '0;
      end else if (wr_irq_mask) begin
         irq_mask <= wr_data[irq_count-1:0];
      end
   end

   // ========================================
   // registered outputs
   always_ff @(posedge clk) begin
      if (srst) begin
         monitor_reset_req <= 1'b0;
         firmware_run      <= 1'b0;
         cpu_run           <= 1'b0;
         watchdog_run      <= 1'b0;
         internal_osc_on   <= 1'b0;
         irq               <= 1'b0;
      end else begin
         monitor_reset_req <= clock_fail;
         if (pin_rst || clock_fail || boot_state == st_settle) begin
            firmware_run <= 1'b0;
            cpu_run      <= 1'b0;
         end else if (!cpu_run && !firmware_run) begin
            firmware_run <= 1'b1;
         end else if (firmware_run && firmware_done) begin
            firmware_run <= 1'b0;
            cpu_run      <= 1'b1;
         end
         watchdog_run    <= !pin_rst && !clock_fail;
         internal_osc_on <= internal_osc_running;
         // a mask bit at one hides its status bit from the line
         irq             <= |(irq_status & ~irq_mask);
      end
   end
endmodule : main_clock_monitor_reset
